// file: common/timer_pkg.sv
package timer_pkg;
  localparam int         NCH        = 6;
  localparam int         NSRC       = 16;
  localparam int         NUNF       = 4;
  localparam logic [3:0] OFS_MODE   = 4'h0;
  localparam logic [3:0] OFS_IOC    = 4'h1;
  localparam logic [3:0] OFS_ENA    = 4'h2;
  localparam logic [3:0] OFS_FLAG   = 4'h3;
  localparam logic [3:0] OFS_CNT    = 4'h4;
  localparam logic [3:0] OFS_GRA    = 4'h5;
  localparam logic [7:0] ADDR_STOP  = 8'h60;
  localparam logic [7:0] ADDR_START = 8'h61;
  localparam logic       STOP_RST   = 1'b1;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  // Flag and enable bit layout
  localparam int         FLG_OVF    = 4;
  localparam int         FLG_UNF    = 5;
  localparam int         ENA_TRIG   = 7;
  // Io control: four bits per general register
  localparam int         IOC_CAP    = 2;
  localparam logic [1:0] OUT_KEEP   = 2'h0;
  localparam logic [1:0] OUT_LOW    = 2'h1;
  localparam logic [1:0] OUT_HIGH   = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;
  // Clear source select
  localparam logic [1:0] CLR_NONE   = 2'h0;
  localparam logic [1:0] CLR_CMPA   = 2'h1;
  localparam logic [1:0] CLR_CAPA   = 2'h2;
  // Prescaler taps
  localparam logic [5:0] PRE_DIV4   = 6'h03;
  localparam logic [5:0] PRE_DIV16  = 6'h0f;
  localparam logic [5:0] PRE_DIV64  = 6'h3f;
  // Channel features
  localparam logic [NCH-1:0] FOUR_GR  = 6'h09;
  localparam logic [NCH-1:0] HAS_UNF  = 6'h36;
  localparam int SRC_BASE [NCH] = '{0, 4, 6, 8, 12, 14};
  localparam int UNF_IDX  [NCH] = '{0, 0, 1, 0, 2, 3};

  typedef struct packed {
    logic       buf_en;
    logic       down;
    logic [1:0] clr_sel;
    logic       both;
    logic [2:0] clk_sel;
  } chan_mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic        wr_cnt;
    logic [3:0]  wr_gr;
    logic [15:0] wdata;
  } chan_wr_t;

  typedef struct packed {
    logic [3:0] match;
    logic [3:0] capt;
    logic       ovf;
    logic       unf;
  } chan_evt_t;

  function automatic logic [7:0] reg_addr(input int ch, input logic [3:0] ofs);
    return {4'(ch), ofs};
  endfunction : reg_addr
endpackage : timer_pkg

// file: src/timer_channel.sv
`timescale 1ns/1ps
module timer_channel
  import timer_pkg::*;
#(
  parameter logic HAS_CD = 1'b0
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              tick,
  input  chan_mode_t             mode,
  input  wire logic [15:0]       ioc,
  input  chan_wr_t               wr,
  input  wire logic [3:0]        capture,
  output logic      [15:0]       cnt_q,
  output logic      [3:0][15:0]  gr_q,
  output logic      [3:0][15:0]  gr_next,
  output chan_evt_t              evt,
  output logic      [1:0]        pin_q
);
  logic        clr;
  logic        use_buf;
  logic [15:0] cnt_d;

  always_comb
  begin
    use_buf = HAS_CD & mode.buf_en;
    for (int i = 0; i < 4; i++)
    begin
      evt.capt[i]  = ((i < 2) || (HAS_CD && !use_buf)) && ioc[4*i+IOC_CAP] && capture[i];
      evt.match[i] = ((i < 2) || (HAS_CD && !use_buf)) && !ioc[4*i+IOC_CAP] && tick
                     && (cnt_q == gr_q[i]) && !wr.wr_gr[i];
    end
    clr = ((mode.clr_sel == CLR_CMPA) && evt.match[0])
          || ((mode.clr_sel == CLR_CAPA) && evt.capt[0]);
    // Wrap flags lost to clear or to a counter write
    evt.ovf = tick && !mode.down && (cnt_q == CNT_MAX) && !clr && !wr.wr_cnt;
    evt.unf = tick && mode.down && (cnt_q == 16'h0000) && !clr && !wr.wr_cnt;
    if (clr)
      cnt_d = 16'h0000;
    else if (wr.wr_cnt)
      cnt_d = wr.wdata;
    else if (tick)
      cnt_d = mode.down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    else
      cnt_d = cnt_q;
  end

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      gr_next[i] = gr_q[i];
      if (wr.wr_gr[i])
        gr_next[i] = wr.wdata;
    end
    for (int i = 0; i < 4; i++)
      if (evt.capt[i])
        gr_next[i] = cnt_q;
    if (use_buf)
      for (int j = 0; j < 2; j++)
      begin
        if (evt.match[j])
          gr_next[j] = gr_q[j+2];
        if (evt.capt[j])
          gr_next[j+2] = gr_q[j];
      end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      gr_q <= {4{16'hffff}};
    else
      gr_q <= gr_next;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pin_q <= 2'h0;
    else
      for (int j = 0; j < 2; j++)
        if (evt.match[j])
          case (ioc[4*j +: 2])
            OUT_LOW:    pin_q[j] <= 1'b0;
            OUT_HIGH:   pin_q[j] <= 1'b1;
            OUT_TOGGLE: pin_q[j] <= ~pin_q[j];
            default:    pin_q[j] <= pin_q[j];
          endcase
  end

  clear_match_a: assert property (@(posedge clk) disable iff (rst)
    (mode.clr_sel == CLR_CMPA) && evt.match[0] |=> cnt_q == 16'h0000)
    else $error("counter not cleared after compare match");
  write_load_a: assert property (@(posedge clk) disable iff (rst)
    wr.wr_cnt && !clr |=> cnt_q == $past(wr.wdata))
    else $error("counter write lost");
  gr_write_a: assert property (@(posedge clk) disable iff (rst)
    wr.wr_gr[0] |-> !evt.match[0])
    else $error("match while general register written");
  capture_wins_a: assert property (@(posedge clk) disable iff (rst)
    evt.capt[0] |=> gr_q[0] == $past(cnt_q))
    else $error("capture value not stored");
  buffer_old_a: assert property (@(posedge clk) disable iff (rst)
    use_buf && evt.match[0] |=> gr_q[0] == $past(gr_q[2]))
    else $error("buffer transfer used wrong value");
  wrap_clear_a: assert property (@(posedge clk) disable iff (rst)
    clr |-> !evt.ovf && !evt.unf)
    else $error("wrap flag raised with clear");
  pin_high_a: assert property (@(posedge clk) disable iff (rst)
    evt.match[0] && (ioc[1:0] == OUT_HIGH) |=> pin_q[0])
    else $error("compare pin not driven high");
endmodule : timer_channel

// file: src/timer_trigger_and_contention.sv
`timescale 1ns/1ps
module timer_trigger_and_contention
  import timer_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                addr,
  input  wire logic [15:0]               wdata,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic      [15:0]               rdata,
  input  wire logic                      ext_count_in_a,
  input  wire logic                      ext_count_in_b,
  input  wire logic                      ext_count_in_c,
  input  wire logic                      ext_count_in_d,
  input  wire logic [NCH-1:0][3:0]       capture_in,
  input  wire logic [NSRC-1:0]           transfer_ack,
  output logic      [NSRC-1:0]           transfer_req,
  output logic      [NSRC-1:0]           match_irq,
  output logic      [NCH-1:0]            overflow_irq,
  output logic      [NUNF-1:0]           underflow_irq,
  output logic      [NCH-1:0]            conv_start,
  output logic      [NCH-1:0][1:0]       cmp_out
);
  bus_req_t                  req;
  logic                      stop_q;
  logic [NCH-1:0]            start_q;
  chan_mode_t [NCH-1:0]      mode_q;
  logic [NCH-1:0][15:0]      ioc_q;
  logic [NCH-1:0][7:0]       ena_q;
  logic [NCH-1:0][5:0]       flag_q;
  logic [NCH-1:0][5:0]       armed_q;
  logic [NCH-1:0][5:0]       flag_set;
  logic [NCH-1:0][5:0]       flag_clr;
  logic [5:0]                pre_q;
  logic [3:0]                ext_q;
  logic [3:0]                ext_rise;
  logic [3:0]                ext_fall;
  logic [NCH-1:0]            tick;
  logic [NCH-1:0]            ev_a;
  logic [NCH-1:0]            conv_q;
  chan_wr_t [NCH-1:0]        cwr;
  logic [NCH-1:0][15:0]      cnt;
  logic [NCH-1:0][3:0][15:0] gr;
  logic [NCH-1:0][3:0][15:0] gr_next;
  chan_evt_t [NCH-1:0]       evt;
  logic [NCH-1:0][3:0]       cap_g;
  logic [15:0]               rd_val;
  logic [15:0]               rdata_q;

  assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

  // Module stop control, always reachable
  always_ff @(posedge clk)
  begin
    if (rst)
      stop_q <= STOP_RST;
    else if (req.wr && (req.addr == ADDR_STOP))
      stop_q <= req.wdata[0];
  end

  // Channel configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_q <= '0;
      mode_q  <= '0;
      ioc_q   <= '0;
      ena_q   <= '0;
    end
    else if (req.wr && !stop_q)
    begin
      if (req.addr == ADDR_START)
        start_q <= req.wdata[NCH-1:0];
      for (int c = 0; c < NCH; c++)
        if (req.addr == reg_addr(c, OFS_MODE))
          mode_q[c] <= chan_mode_t'(req.wdata[7:0]);
        else if (req.addr == reg_addr(c, OFS_IOC))
          ioc_q[c] <= req.wdata;
        else if (req.addr == reg_addr(c, OFS_ENA))
          ena_q[c] <= req.wdata[7:0];
    end
  end

  // Prescaler and external input edges
  always_ff @(posedge clk)
  begin
    if (rst)
      pre_q <= 6'h00;
    else if (!stop_q)
      pre_q <= pre_q + 6'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ext_q <= 4'h0;
    else
      ext_q <= {ext_count_in_d, ext_count_in_c, ext_count_in_b, ext_count_in_a};
  end

  // Edge detection needs pulses of at least one clock
  assign ext_rise = {ext_count_in_d, ext_count_in_c, ext_count_in_b, ext_count_in_a}
                    & ~ext_q;
  assign ext_fall = ~{ext_count_in_d, ext_count_in_c, ext_count_in_b, ext_count_in_a}
                    & ext_q;

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      case (mode_q[c].clk_sel)
        3'h0:    tick[c] = 1'b1;
        3'h1:    tick[c] = (pre_q[1:0] == PRE_DIV4[1:0]);
        3'h2:    tick[c] = (pre_q[3:0] == PRE_DIV16[3:0]);
        3'h3:    tick[c] = (pre_q == PRE_DIV64);
        default: tick[c] = ext_rise[mode_q[c].clk_sel[1:0]]
                           | (mode_q[c].both & ext_fall[mode_q[c].clk_sel[1:0]]);
      endcase
      tick[c]  = tick[c] & start_q[c] & ~stop_q;
      cap_g[c] = stop_q ? 4'h0 : capture_in[c];
    end
  end

  // Write strobes toward the counters and general registers
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      cwr[c].wdata  = req.wdata;
      cwr[c].wr_cnt = req.wr && !stop_q && (req.addr == reg_addr(c, OFS_CNT));
      for (int i = 0; i < 4; i++)
        cwr[c].wr_gr[i] = req.wr && !stop_q && ((i < 2) || FOUR_GR[c])
                          && (req.addr == reg_addr(c, OFS_GRA + 4'(i)));
    end
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    timer_channel #(
      .HAS_CD (FOUR_GR[g])
    ) u_ch (
      .clk     (clk),
      .rst     (rst),
      .tick    (tick[g]),
      .mode    (mode_q[g]),
      .ioc     (ioc_q[g]),
      .wr      (cwr[g]),
      .capture (cap_g[g]),
      .cnt_q   (cnt[g]),
      .gr_q    (gr[g]),
      .gr_next (gr_next[g]),
      .evt     (evt[g]),
      .pin_q   (cmp_out[g])
    );
  end

  // Flag set and clear terms
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      flag_set[c] = {evt[c].unf & HAS_UNF[c], evt[c].ovf, evt[c].match | evt[c].capt};
      ev_a[c]     = flag_set[c][0];
      flag_clr[c] = '0;
      if (req.wr && !stop_q && (req.addr == reg_addr(c, OFS_FLAG)))
        flag_clr[c] = ~req.wdata[5:0] & armed_q[c];
      // Transfer service clears cannot act while stopped
      for (int i = 0; i < 4; i++)
        if (((i < 2) || FOUR_GR[c]) && !stop_q && transfer_ack[SRC_BASE[c] + i])
          flag_clr[c][i] = 1'b1;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      flag_q <= '0;
    else
      for (int c = 0; c < NCH; c++)
        flag_q[c] <= flag_set[c] | (flag_q[c] & ~flag_clr[c]);
  end

  // Bits seen as one by a read, eligible for a zero-write clear
  always_ff @(posedge clk)
  begin
    if (rst)
      armed_q <= '0;
    else
      for (int c = 0; c < NCH; c++)
        if (req.rd && !stop_q && (req.addr == reg_addr(c, OFS_FLAG)))
          armed_q[c] <= flag_q[c];
        else if (req.wr && !stop_q && (req.addr == reg_addr(c, OFS_FLAG)))
          armed_q[c] <= 6'h00;
  end

  // Requests toward interrupt and transfer controllers
  always_comb
  begin
    match_irq     = '0;
    underflow_irq = '0;
    for (int c = 0; c < NCH; c++)
    begin
      for (int i = 0; i < 4; i++)
        if ((i < 2) || FOUR_GR[c])
          match_irq[SRC_BASE[c] + i] = flag_q[c][i] & ena_q[c][i];
      overflow_irq[c] = flag_q[c][FLG_OVF] & ena_q[c][FLG_OVF];
      if (HAS_UNF[c])
        underflow_irq[UNF_IDX[c]] = flag_q[c][FLG_UNF] & ena_q[c][FLG_UNF];
    end
  end

  assign transfer_req = match_irq;

  // Conversion start, one pulse per channel from register A
  always_ff @(posedge clk)
  begin
    if (rst)
      conv_q <= '0;
    else
      for (int c = 0; c < NCH; c++)
        conv_q[c] <= ev_a[c] & ena_q[c][ENA_TRIG];
  end

  assign conv_start = conv_q;

  // Read decode; general registers read their post-capture value
  always_comb
  begin
    rd_val = 16'h0000;
    if (req.addr == ADDR_STOP)
      rd_val = {15'h0000, stop_q};
    else if (req.addr == ADDR_START)
      rd_val = {10'h000, start_q};
    else if (!stop_q)
      for (int c = 0; c < NCH; c++)
        if (req.addr == reg_addr(c, OFS_MODE))
          rd_val = {8'h00, mode_q[c]};
        else if (req.addr == reg_addr(c, OFS_IOC))
          rd_val = ioc_q[c];
        else if (req.addr == reg_addr(c, OFS_ENA))
          rd_val = {8'h00, ena_q[c]};
        else if (req.addr == reg_addr(c, OFS_FLAG))
          rd_val = {10'h000, flag_q[c]};
        else if (req.addr == reg_addr(c, OFS_CNT))
          rd_val = cnt[c];
        else
          for (int i = 0; i < 4; i++)
            if (((i < 2) || FOUR_GR[c]) && (req.addr == reg_addr(c, OFS_GRA + 4'(i))))
              rd_val = gr_next[c][i];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 16'h0000;
    else if (req.rd)
      rdata_q <= rd_val;
    else
      rdata_q <= 16'h0000;
  end

  assign rdata = rdata_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  stop_halts_a: assert property (stop_q |-> (tick == '0) ##1 (conv_start == '0))
    else $error("activity while module stopped");
  stop_read_a: assert property (
    stop_q && req.rd && (req.addr == reg_addr(0, OFS_CNT)) |=> rdata == 16'h0000)
    else $error("register readable while stopped");
  conv_pulse_a: assert property (
    ev_a[0] && ena_q[0][ENA_TRIG] |=> conv_start[0])
    else $error("conversion request missing");
  conv_cause_a: assert property (
    conv_start[0] |-> $past(ev_a[0]) && $past(ena_q[0][ENA_TRIG]))
    else $error("conversion request without cause");
  irq_raise_a: assert property (
    flag_set[1][0] && ena_q[1][0] |=> match_irq[SRC_BASE[1]] ##0 transfer_req[SRC_BASE[1]])
    else $error("match request not raised");
  ack_clear_a: assert property (
    transfer_ack[0] && !stop_q && !flag_set[0][0] |=> !flag_q[0][0])
    else $error("transfer service did not clear flag");
  unarmed_keep_a: assert property (
    flag_q[0][0] && !armed_q[0][0] && !transfer_ack[SRC_BASE[0]]
    && req.wr && (req.addr == reg_addr(0, OFS_FLAG)) |=> flag_q[0][0])
    else $error("flag cleared without prior read");
  set_wins_a: assert property (flag_set[1][FLG_OVF] |=> flag_q[1][FLG_OVF]
    ##1 (flag_q[1][FLG_OVF] || $past(flag_clr[1][FLG_OVF])))
    else $error("overflow flag lost");
  cwr_ovf_a: assert property (cwr[1].wr_cnt |-> !evt[1].ovf && !evt[1].unf)
    else $error("wrap flag raised during counter write");

  clr_cmp_c: cover property (mode_q[0].clr_sel == CLR_CMPA && evt[0].match[0]);
  ovf_c: cover property (flag_set[1][FLG_OVF] ##1 overflow_irq[1]);
  conv_c: cover property (conv_start[0]);
  ack_c: cover property (transfer_ack[0] && flag_q[0][0] ##1 !flag_q[0][0]);
endmodule : timer_trigger_and_contention

// file: tb/xfer_model.sv
`timescale 1ns/1ps
module xfer_model
  import timer_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            en,
  input  wire logic            slow,
  input  wire logic [NSRC-1:0] transfer_req,
  input  wire logic [NCH-1:0]  conv_start,
  output logic      [NSRC-1:0] transfer_ack,
  output int                   conv_count
);
  logic [NSRC-1:0][1:0] wait_q;

  // Serve each pending source once, at once or after three cycles
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      transfer_ack[i] <= 1'b0;
      if (rst || !en || !transfer_req[i] || transfer_ack[i])
        wait_q[i] <= 2'h0;
      else if (wait_q[i] == (slow ? 2'h3 : 2'h0))
      begin
        transfer_ack[i] <= 1'b1;
        wait_q[i]       <= 2'h0;
      end
      else
        wait_q[i] <= wait_q[i] + 2'h1;
    end
  end

  // Converter counts start requests
  always_ff @(posedge clk)
  begin
    if (rst)
      conv_count <= 0;
    else
      conv_count <= conv_count + $countones(conv_start);
  end
endmodule : xfer_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import timer_pkg::*;
;
  logic                clk;
  logic                rst;
  logic                wr_en;
  logic                rd_en;
  logic                xen;
  logic                xslow;
  logic [7:0]          addr;
  logic [15:0]         wdata;
  logic [15:0]         rdata;
  logic [15:0]         v;
  logic [15:0]         c;
  logic [3:0]          ext;
  logic [NCH-1:0][3:0] capture_in;
  logic [NSRC-1:0]     transfer_req;
  logic [NSRC-1:0]     transfer_ack;
  logic [NSRC-1:0]     match_irq;
  logic [NCH-1:0]      overflow_irq;
  logic [NCH-1:0]      conv_start;
  logic [NUNF-1:0]     underflow_irq;
  logic [NCH-1:0][1:0] cmp_out;
  chan_mode_t          m;
  int                  bad_count;
  int                  checked;
  int                  conv_count;
  int                  n;
  int                  k;
  int                  t;

  timer_trigger_and_contention timer_trigger_and_contention_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .ext_count_in_a(ext[0]), .ext_count_in_b(ext[1]),
    .ext_count_in_c(ext[2]), .ext_count_in_d(ext[3]), .capture_in(capture_in),
    .transfer_ack(transfer_ack), .transfer_req(transfer_req), .match_irq(match_irq),
    .overflow_irq(overflow_irq), .underflow_irq(underflow_irq),
    .conv_start(conv_start), .cmp_out(cmp_out)
  );

  xfer_model xfer_model_i (
    .clk(clk), .rst(rst), .en(xen), .slow(xslow), .transfer_req(transfer_req),
    .conv_start(conv_start), .transfer_ack(transfer_ack), .conv_count(conv_count)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [7:0] ra(input int ch, input logic [3:0] ofs);
    return {ch[3:0], ofs};
  endfunction : ra

  function automatic int period(input int nv);
    return nv + 1;
  endfunction : period

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= w;
    rd_en <= r;
    addr  <= a;
    wdata <= d;
  endtask : op

  task automatic done();
    @(posedge clk);
    wr_en      <= 1'b0;
    rd_en      <= 1'b0;
    capture_in <= '0;
    #1;
  endtask : done

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    op(1'b1, 1'b0, a, d);
    done();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    op(1'b0, 1'b1, a, 16'h0000);
    done();
    v = rdata;
  endtask : rd

  task automatic idle(input int cy);
    repeat (cy) @(posedge clk);
    #1;
  endtask : idle

  task automatic wait_conv();
    t = 0;
    while (t < 100)
    begin
      @(posedge clk);
      #1;
      t++;
      if (conv_start[0] === 1'b1)
        break;
    end
    if (conv_start[0] !== 1'b1)
    begin
      bad_count++;
      $display("Error conv_start expected 1 seen 0");
      give_verdict();
    end
  endtask : wait_conv

  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("Error run expected end seen timeout");
    give_verdict();
  end

  initial
  begin
    void'($urandom(32'hb7fb));
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    ext = 4'h0;
    capture_in = '0;
    xen = 1'b0;
    xslow = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("match_irq", 16'h0000, match_irq);
    wr(ra(0, OFS_CNT), 16'h1234);
    rd(ra(0, OFS_CNT));
    chk("stopped read", 16'h0000, v);
    wr(ADDR_STOP, 16'h0000);
    rd(ra(0, OFS_CNT));
    chk("stopped write", 16'h0000, v);
    // Periodic match with clear on register A
    n = 3 + $urandom % 8;
    m = '0;
    m.clr_sel = CLR_CMPA;
    wr(ra(0, OFS_MODE), {8'h00, m});
    wr(ra(0, OFS_IOC), {14'h0000, OUT_HIGH});
    wr(ra(0, OFS_GRA), 16'(n));
    wr(ra(0, OFS_ENA), 16'h0081);
    xen <= 1'b1;
    wr(ADDR_START, 16'h0001);
    for (k = 0; k < 2; k++)
    begin
      xslow <= k[0];
      wait_conv();
      chk("cmp_out", 16'h0001, {15'h0000, cmp_out[0][0]});
      wait_conv();
      chk("period", 16'(period(n)), 16'(t));
    end
    idle(1);
    chk("conv_count", 16'h0004, 16'(conv_count));
    // Flag clearing by software
    xen <= 1'b0;
    idle(n + 3);
    wr(ADDR_START, 16'h0000);
    chk("transfer_req", 16'h0001, {15'h0000, transfer_req[0]});
    wr(ra(0, OFS_FLAG), 16'h0000);
    rd(ra(0, OFS_FLAG));
    chk("flag unarmed", 16'h0001, {15'h0000, v[0]});
    wr(ra(0, OFS_FLAG), 16'h0000);
    chk("irq cleared", 16'h0000, {15'h0000, match_irq[0]});
    // Counter write beats increment
    wr(ra(1, OFS_MODE), 16'h0000);
    wr(ADDR_START, 16'h0002);
    repeat (8)
    begin
      c = 16'($urandom);
      op(1'b1, 1'b0, ra(1, OFS_CNT), c);
      op(1'b0, 1'b1, ra(1, OFS_CNT), 16'h0000);
      done();
      chk("cnt write", c, rdata);
    end
    // Wrap flags
    wr(ra(1, OFS_ENA), 16'h0031);
    wr(ra(1, OFS_CNT), 16'hfffe);
    idle(4);
    chk("overflow", 16'h0001, {15'h0000, overflow_irq[1]});
    m = '0;
    m.down = 1'b1;
    wr(ra(1, OFS_MODE), {8'h00, m});
    wr(ra(1, OFS_CNT), 16'h0002);
    idle(5);
    chk("underflow", 16'h0001, {15'h0000, underflow_irq[0]});
    // Clear together with overflow
    m = '0;
    m.clr_sel = CLR_CMPA;
    wr(ra(2, OFS_MODE), {8'h00, m});
    wr(ra(2, OFS_ENA), 16'h0011);
    wr(ra(2, OFS_CNT), 16'hfffc);
    wr(ADDR_START, 16'h0004);
    idle(8);
    chk("clear ovf", 16'h0000, {15'h0000, overflow_irq[2]});
    chk("clear match", 16'h0001, {15'h0000, match_irq[6]});
    // Capture against bus access
    wr(ra(3, OFS_IOC), 16'h0004);
    c = 16'($urandom);
    wr(ra(3, OFS_CNT), c);
    op(1'b1, 1'b0, ra(3, OFS_GRA), ~c);
    capture_in[3][0] <= 1'b1;
    done();
    rd(ra(3, OFS_GRA));
    chk("capture write", c, v);
    c = 16'($urandom);
    wr(ra(3, OFS_CNT), c);
    op(1'b0, 1'b1, ra(3, OFS_GRA), 16'h0000);
    capture_in[3][0] <= 1'b1;
    done();
    chk("capture read", c, rdata);
    // External count clock
    m = '0;
    m.clk_sel = 3'h4;
    wr(ra(4, OFS_MODE), {8'h00, m});
    wr(ADDR_START, 16'h0010);
    k = 3 + $urandom % 6;
    repeat (k)
    begin
      repeat (3) @(posedge clk);
      ext[0] <= 1'b1;
      repeat (3) @(posedge clk);
      ext[0] <= 1'b0;
    end
    idle(4);
    rd(ra(4, OFS_CNT));
    chk("ext count", 16'(k), v);
    wr(ra(1, OFS_ENA), 16'h0000);
    wr(ra(2, OFS_ENA), 16'h0000);
    wr(ADDR_STOP, 16'h0001);
    give_verdict();
  end
endmodule : testbench
